// *** rtl/dr1_defs.svh ***
/*
 Constants of the extended diagnostic record builder: register offsets,
 field positions, fixed record codes and reset values.
 Assumes it is included by bare name from the package and the record builder.
*/
// Function
// - Record is 16 bytes, basic four first
// - Alarm variant: byte 4 type code 70h
// - Counter variant: byte 4 type code 76h
// - Byte 4 bit 7 flags more types
// - Byte 5 holds 08h bits per channel
// - Alarm variant: byte 6 holds 08h channels
// - Counter variant: byte 6 holds 04h channels
// - Alarm byte 7: four input group errors
// - Counter byte 7: one error per counter
// - Alarm bytes 8-11: lost flags, even bits
// - Counters 0-2: bit2 overflow, bit3 compare lost
// - Counter 3 byte 11: five lost flags
// - Going message only while release enabled
`ifndef DR1_DEFS_SVH
`define DR1_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DR1_A_REC0       8'h00
`define DR1_A_REC1       8'h04
`define DR1_A_REC2       8'h08
`define DR1_A_REC3       8'h0c
`define DR1_A_CTRL       8'h10
`define DR1_A_STAT       8'h14
`define DR1_A_MASK       8'h18

// ----------------------------------------------------------------
// Control, status and mask fields
// ----------------------------------------------------------------
`define DR1_CTRL_VAR     0
`define DR1_CTRL_MORE    1
`define DR1_CTRL_REL     2
`define DR1_CTRL_W       3
`define DR1_CTRL_RST     3'h0
`define DR1_ST_LOST      0
`define DR1_ST_COME      1
`define DR1_ST_GO        2
`define DR1_ST_W         3
`define DR1_ST_RST       3'h0
`define DR1_MASK_RST     3'h0

// ----------------------------------------------------------------
// Fixed record contents
// ----------------------------------------------------------------
`define DR1_TYPE_DI      7'h70
`define DR1_TYPE_FM      7'h76
`define DR1_BITS_PER_CH  8'h08
`define DR1_CH_DI        8'h08
`define DR1_CH_FM        8'h04
`define DR1_FM_OVF_BIT   2
`define DR1_FM_CMP_BIT   3
`define DR1_LOST_W       16
`define DR1_GRP_W        4
`define DR1_NUM_DI       8
`define DR1_NUM_CNT      4
`define DR1_NUM_DI_LOST  16
`define DR1_LOST_DI_MASK 16'hffff
`define DR1_LOST_FM_MASK 16'h07ff
`define DR1_GRP_RST      4'h0

`endif

// *** rtl/dr1_pkg.sv ***
/*
 Types used by the record builder; the flag store does not import them.
 Assumes dr1_defs.svh is on the include path.
*/
`include "dr1_defs.svh"

package dr1_pkg;
    // Function variant served by the record
    typedef enum logic {
        DR1_ALARM,
        DR1_COUNTER
    } dr1_variant_t;

    typedef logic [`DR1_LOST_W-1:0] dr1_lost_t;
endpackage

// *** rtl/dr1_flag_if.sv ***
/*
 Interface between the record builder and the sticky lost-flag store.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface dr1_flag_if #(
    parameter int W = 16
);
    logic [W-1:0] set;
    logic         clr_all;
    logic [W-1:0] q;

    modport owner (input set, input clr_all, output q);
    modport user  (output set, output clr_all, input q);
endinterface

`default_nettype wire

// *** rtl/dr1_flags.sv ***
/*
 Sticky store for the lost-process-interrupt flags.
 Assumes set pulses come from logic on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module dr1_flags #(
    parameter int W = 16
) (
    input  wire logic   ref_clk,
    input  wire logic   arst_n,
    dr1_flag_if.owner   fl
);
    logic [W-1:0] flag_q;
    logic [W-1:0] flag_d;

    // A new loss in the clearing cycle survives the clear
    assign flag_d = (flag_q & ~{W{fl.clr_all}}) | fl.set;
    assign fl.q   = flag_q;

    // Flag register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule

`default_nettype wire

// *** rtl/dr1_record.sv ***
/*
 Builder of the 16-byte extended diagnostic record for the alarm-input
 and counter variants, with its register port and interrupt.
 Assumes all inputs come from logic on ref_clk; the basic record is
 supplied ready-made by the host unit.
*/
// The plain strobed port and the address map were decided locally.
`timescale 1ns/100ps
`include "dr1_defs.svh"
`default_nettype none

module dr1_record
    import dr1_pkg::*;
#(
    parameter int NUM_DI  = `DR1_NUM_DI,
    parameter int NUM_CNT = `DR1_NUM_CNT
) (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [31:0] basic_rec,
    input  wire logic [3:0]  group_err,
    input  wire logic [15:0] lost_evt,
    output logic             diag_coming,
    output logic             diag_going,
    output logic             irq
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------

    // The record layout only has room for these channel counts
    if (NUM_DI != `DR1_NUM_DI) begin : g_chk_di
        $error("NUM_DI must be 8");
    end
    if (NUM_CNT != `DR1_NUM_CNT) begin : g_chk_cnt
        $error("NUM_CNT must be 4");
    end

    // Sixteen alarm inputs must each find a flag in the store
    if (`DR1_LOST_W < `DR1_NUM_DI_LOST) begin : g_chk_lost
        $error("lost-flag store narrower than the alarm inputs");
    end

    // ----------------------------------------------------------------
    // Packing functions
    // ----------------------------------------------------------------

    // Alarm inputs: input n lands on word bit 2n, odd bits stay zero;
    // sixteen inputs fill bytes 8-11, four to a byte
    function automatic logic [31:0] pack_di(input logic [15:0] l);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < `DR1_NUM_DI_LOST; i++) begin
            r[2*i] = l[i];
        end
        return r;
    endfunction

    // Counters: two flags for counters 0-2, five for counter 3;
    // flags 15:11 have no place in this layout
    function automatic logic [31:0] pack_fm(input logic [15:0] l);
        logic [31:0] r;
        r = '0;
        for (int k = 0; k < `DR1_NUM_CNT - 1; k++) begin
            r[8*k + `DR1_FM_OVF_BIT] = l[2*k];
            r[8*k + `DR1_FM_CMP_BIT] = l[2*k + 1];
        end
        r[28:24] = l[10:6];
        return r;
    endfunction

    // Relevant lost inputs per variant; the rest are ignored
    function automatic logic [15:0] lost_mask(input dr1_variant_t v);
        logic [15:0] m;
        m = (v == DR1_ALARM) ? `DR1_LOST_DI_MASK : `DR1_LOST_FM_MASK;
        return m;
    endfunction

    // ----------------------------------------------------------------
    // Registers and wires
    // ----------------------------------------------------------------
    logic [`DR1_CTRL_W-1:0] ctrl_q;
    logic [`DR1_CTRL_W-1:0] ctrl_d;
    logic [`DR1_ST_W-1:0]   stat_q;
    logic [`DR1_ST_W-1:0]   stat_d;
    logic [`DR1_ST_W-1:0]   mask_q;
    logic [`DR1_ST_W-1:0]   mask_d;
    logic [3:0]             grp_q;
    logic [31:0]            rdata_q;
    logic [31:0]            rdata_d;
    logic                   coming_q;
    logic                   going_q;

    dr1_variant_t           variant;
    logic                   more_types;
    logic                   release_en;
    logic [6:0]             type_code;
    logic [7:0]             chan_count;
    logic [31:0]            word0;
    logic [31:0]            word1;
    logic [31:0]            word2;
    logic [31:0]            word3;

    logic                   hit_rec0;
    logic                   hit_rec1;
    logic                   hit_rec2;
    logic                   hit_rec3;
    logic                   hit_ctrl;
    logic                   hit_stat;
    logic                   hit_mask;
    logic                   wr_ctrl;
    logic                   wr_mask;
    logic                   rd_stat;
    logic                   rd_lost;
    logic                   var_change;

    logic [15:0]            lost_set;
    logic                   any_lost;
    logic                   err_rise;
    logic                   err_fall;
    logic [`DR1_ST_W-1:0]   stat_set;

    dr1_flag_if #(.W(`DR1_LOST_W)) flag_bus ();

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------

    // One word per register; unmapped addresses hit nothing
    // Exact compare, so a misaligned address also hits nothing
    assign hit_rec0 = (reg_addr == `DR1_A_REC0);
    assign hit_rec1 = (reg_addr == `DR1_A_REC1);
    assign hit_rec2 = (reg_addr == `DR1_A_REC2);
    assign hit_rec3 = (reg_addr == `DR1_A_REC3);
    assign hit_ctrl = (reg_addr == `DR1_A_CTRL);
    assign hit_stat = (reg_addr == `DR1_A_STAT);
    assign hit_mask = (reg_addr == `DR1_A_MASK);

    // Strobe qualification
    assign wr_ctrl  = reg_wr & hit_ctrl;
    assign wr_mask  = reg_wr & hit_mask;
    assign rd_stat  = reg_rd & hit_stat;
    assign rd_lost  = reg_rd & hit_rec2;

    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------

    // Variant, more-types flag and diagnostic interrupt release
    assign variant    = ctrl_q[`DR1_CTRL_VAR] ? DR1_COUNTER : DR1_ALARM;
    assign more_types = ctrl_q[`DR1_CTRL_MORE];
    assign release_en = ctrl_q[`DR1_CTRL_REL];
    // A write that flips the variant invalidates the lost flags
    assign var_change = wr_ctrl &
                        (reg_wdata[`DR1_CTRL_VAR] != ctrl_q[`DR1_CTRL_VAR]);

    // Writes to control and mask store the low bits only
    assign ctrl_d = wr_ctrl ? reg_wdata[`DR1_CTRL_W-1:0] : ctrl_q;
    assign mask_d = wr_mask ? reg_wdata[`DR1_ST_W-1:0] : mask_q;

    // ----------------------------------------------------------------
    // Lost-flag store
    // ----------------------------------------------------------------

    // Flags belong to one variant, so a variant switch wipes them;
    // reading the lost-flag word hands them to software and clears them
    // (the read returns the values held before the clear)
    assign lost_set         = lost_evt & lost_mask(variant);
    assign flag_bus.set     = lost_set;
    assign flag_bus.clr_all = rd_lost | var_change;

    dr1_flags #(
        .W (`DR1_LOST_W)
    ) u_flags (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .fl      (flag_bus.owner)
    );

    // ----------------------------------------------------------------
    // Record assembly
    // ----------------------------------------------------------------

    // Channel type and channel count per variant
    // The counter code marks the block as a function module
    assign type_code  = (variant == DR1_ALARM) ? `DR1_TYPE_DI
                                               : `DR1_TYPE_FM;
    assign chan_count = (variant == DR1_ALARM) ? `DR1_CH_DI
                                               : `DR1_CH_FM;

    // Bytes 0-3 repeat the basic record
    assign word0 = basic_rec;

    // Bytes 4-7: type, bits per channel, channels, group errors;
    // group bits mean input groups or counters by variant
    assign word1 = {4'h0, grp_q,
                    chan_count,
                    `DR1_BITS_PER_CH,
                    more_types, type_code};

    // Bytes 8-11: lost flags in the variant's layout
    assign word2 = (variant == DR1_ALARM) ? pack_di(flag_bus.q)
                                          : pack_fm(flag_bus.q);

    // Bytes 12-15 are reserved
    assign word3 = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------

    // Unmapped reads return zero; the output is registered so that
    // software sees data only in the cycle after its read strobe
    assign rdata_d = !reg_rd  ? 32'h0000_0000 :
                     hit_rec0 ? word0 :
                     hit_rec1 ? word1 :
                     hit_rec2 ? word2 :
                     hit_rec3 ? word3 :
                     hit_ctrl ? {29'h0, ctrl_q} :
                     hit_stat ? {29'h0, stat_q} :
                     hit_mask ? {29'h0, mask_q} :
                                32'h0000_0000;

    // ----------------------------------------------------------------
    // Events and interrupt
    // ----------------------------------------------------------------

    // Error transitions across the channel groups
    // Image starts at zero, the no-error level, so an error present when reset ends makes a rising edge
    assign any_lost = |lost_set;
    assign err_rise = |(group_err & ~grp_q);
    assign err_fall = |(~group_err & grp_q);

    // Diagnostic messages need the release; a cleared error only
    // reports its going while the release is still on
    assign stat_set[`DR1_ST_LOST] = any_lost;
    assign stat_set[`DR1_ST_COME] = err_rise & release_en;
    assign stat_set[`DR1_ST_GO]   = err_fall & release_en;

    // Read clears status; an event in the same cycle wins
    assign stat_d = (stat_q & ~{`DR1_ST_W{rd_stat}}) | stat_set;

    // ----------------------------------------------------------------
    // Interrupt and outputs
    // ----------------------------------------------------------------

    // Level interrupt from unmasked status; it stays high until
    // software reads the status word or masks the bits
    assign irq = |(stat_q & mask_q);

    // Data outputs come straight from flip-flops
    assign reg_rdata   = rdata_q;
    assign diag_coming = coming_q;
    assign diag_going  = going_q;

    // ----------------------------------------------------------------
    // Flip-flops
    // ----------------------------------------------------------------

    // Software-visible registers
    // Reset leaves the alarm variant, release off, all masked
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `DR1_CTRL_RST;
            mask_q <= `DR1_MASK_RST;
            stat_q <= `DR1_ST_RST;
        end else begin
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
        end
    end

    // Group error image and one-cycle message pulses
    // Messages rise in the same cycle as their status bit
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            grp_q    <= `DR1_GRP_RST;
            coming_q <= 1'b0;
            going_q  <= 1'b0;
        end else begin
            grp_q    <= group_err;
            coming_q <= stat_set[`DR1_ST_COME];
            going_q  <= stat_set[`DR1_ST_GO];
        end
    end

    // Read data stands for the cycle after the read strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

endmodule

`default_nettype wire

// *** sim/dr1_record_asserts.sv ***
/*
 Checker of the record builder's port behaviour.
 Assumes it is bound to dr1_record and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none

module dr1_record_asserts (
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [31:0] basic_rec,
    input wire logic [3:0]  group_err,
    input wire logic [15:0] lost_evt,
    input wire logic        diag_coming,
    input wire logic        diag_going,
    input wire logic        irq
);
    logic [2:0] ctrl_q;
    logic [2:0] mask_q;
    wire        rd0;
    wire        rd1;
    wire        rd2;
    wire        rd3;

    // ------------------------------------------------
    // Decoded reads and shadows of control and mask
    // ------------------------------------------------
    assign rd0 = reg_rd && reg_addr == 8'h00;
    assign rd1 = reg_rd && reg_addr == 8'h04;
    assign rd2 = reg_rd && reg_addr == 8'h08;
    assign rd3 = reg_rd && reg_addr == 8'h0c;

    // Track what software last wrote
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= 3'h0;
            mask_q <= 3'h0;
        end else if (reg_wr) begin
            if (reg_addr == 8'h10) ctrl_q <= reg_wdata[2:0];
            if (reg_addr == 8'h18) mask_q <= reg_wdata[2:0];
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    property p_rec0; rd0 |=> reg_rdata == $past(basic_rec); endproperty
    a_rec0: assert property (p_rec0) else $error("word 0 differs from basic record");
    property p_head; rd1 |=> reg_rdata[7:0] == {$past(ctrl_q[1]), ($past(ctrl_q[0]) ? 7'h76 : 7'h70)}; endproperty
    a_head: assert property (p_head) else $error("type byte wrong");
    property p_bits; rd1 |=> reg_rdata[15:8] == 8'h08; endproperty
    a_bits: assert property (p_bits) else $error("bits per channel wrong");
    property p_chan; rd1 |=> reg_rdata[23:16] == ($past(ctrl_q[0]) ? 8'h04 : 8'h08); endproperty
    a_chan: assert property (p_chan) else $error("channel count wrong");
    property p_grp; rd1 |=> reg_rdata[31:24] == {4'h0, $past(group_err, 2)}; endproperty
    a_grp: assert property (p_grp) else $error("group error byte wrong");
    property p_di_lost; rd2 && !ctrl_q[0] |=> (reg_rdata & 32'haaaaaaaa) == 32'h0; endproperty
    a_di_lost: assert property (p_di_lost) else $error("odd lost bits set");
    property p_cnt_lost; rd2 && ctrl_q[0] |=> (reg_rdata & 32'he0f3f3f3) == 32'h0; endproperty
    a_cnt_lost: assert property (p_cnt_lost) else $error("counter lost spare bits set");
    property p_rec3; rd3 |=> reg_rdata == 32'h0; endproperty
    a_rec3: assert property (p_rec3) else $error("reserved word not zero");
    property p_going; diag_going |-> ctrl_q[2] || $past(ctrl_q[2]); endproperty
    a_going: assert property (p_going) else $error("going message without release");
    property p_irq; mask_q == 3'h0 |-> !irq; endproperty
    a_irq: assert property (p_irq) else $error("interrupt while all masked");

    // Main scenarios reached
    c_come: cover property (diag_coming);
    c_go: cover property (diag_going);
    c_cnt: cover property (rd2 && ctrl_q[0]);
endmodule

bind dr1_record dr1_record_asserts u_chk (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .basic_rec(basic_rec),
    .group_err(group_err), .lost_evt(lost_evt), .diag_coming(diag_coming),
    .diag_going(diag_going), .irq(irq)
);

`default_nettype wire

// *** sim/dr1_record_test.sv ***
/*
 Self-checking bench of the record builder over its register port.
 Assumes the checker file is compiled beside it.
*/
`timescale 1ns/100ps
`default_nettype none

module dr1_record_test;
    logic        ref_clk   = 1'b0;
    logic        arst_n    = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] basic_rec = 32'h44332211;
    logic [3:0]  group_err = 4'h0;
    logic [15:0] lost_evt  = 16'h0;
    wire logic [31:0] reg_rdata;
    wire logic   diag_coming;
    wire logic   diag_going;
    wire logic   irq;
    int          n_fail, cmp_count, cyc, n_come, n_go;
    logic [15:0] cv [5] = '{16'hf801, 16'h0002, 16'h0004, 16'h0030, 16'h07c0};
    logic [31:0] cw [5] = '{32'h4, 32'h8, 32'h400, 32'h000c0000, 32'h1f000000};

    always #4 ref_clk = ~ref_clk;

    dr1_record dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .basic_rec(basic_rec),
        .group_err(group_err), .lost_evt(lost_evt), .diag_coming(diag_coming),
        .diag_going(diag_going), .irq(irq)
    );

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task report_and_stop;
        $display("checks=%0d errors=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task pulse(input logic [15:0] v);
        @(posedge ref_clk);
        lost_evt <= v;
        @(posedge ref_clk);
        lost_evt <= 16'h0;
    endtask
    task set_grp(input logic [3:0] g);
        @(posedge ref_clk);
        group_err <= g;
        repeat (2) @(posedge ref_clk);
    endtask

    // Count message pulses and cut a hang short
    always @(negedge ref_clk) begin
        cyc++;
        n_come += int'(diag_coming === 1'b1);
        n_go += int'(diag_going === 1'b1);
        if (cyc == 4000) begin
            n_fail++;
            report_and_stop;
        end
    end

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h0);
        rd(8'h18, 32'h0);
        rd(8'h0c, 32'h0);
        rd(8'h1c, 32'h0);
        rd(8'h00, 32'h44332211);
        rd(8'h04, 32'h00080870);
        wr(8'h10, 32'h2);
        rd(8'h04, 32'h000808f0);
        // Alarm variant with release on: arriving and leaving errors
        wr(8'h10, 32'h4);
        wr(8'h18, 32'h7);
        set_grp(4'h5);
        chk({31'h0, irq}, 32'h1);
        rd(8'h04, 32'h05080870);
        rd(8'h14, 32'h2);
        chk({31'h0, irq}, 32'h0);
        set_grp(4'h0);
        rd(8'h14, 32'h4);
        chk(n_come, 32'h1);
        chk(n_go, 32'h1);
        // Release off: no messages
        wr(8'h10, 32'h0);
        set_grp(4'h3);
        set_grp(4'h0);
        rd(8'h14, 32'h0);
        chk(n_go, 32'h1);
        chk(n_come, 32'h1);
        // Alarm lost flags on even bits, cleared by reading
        pulse(16'h87a5);
        rd(8'h08, 32'h40154411);
        rd(8'h08, 32'h0);
        rd(8'h14, 32'h1);
        // Counter variant
        wr(8'h10, 32'h1);
        rd(8'h04, 32'h00040876);
        for (int i = 0; i < 5; i++) begin
            pulse(cv[i]);
            rd(8'h08, cw[i]);
        end
        set_grp(4'h8);
        rd(8'h04, 32'h08040876);
        wr(8'h0c, 32'hffffffff);
        rd(8'h0c, 32'h0);
        wr(8'h14, 32'h7);
        rd(8'h14, 32'h1);
        // Masking of the interrupt
        wr(8'h18, 32'h0);
        pulse(16'h0001);
        #1;
        chk({31'h0, irq}, 32'h0);
        wr(8'h18, 32'h1);
        #1;
        chk({31'h0, irq}, 32'h1);
        rd(8'h14, 32'h1);
        chk({31'h0, irq}, 32'h0);
        // Reset in mid-run brings back the alarm defaults
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(8'h10, 32'h0);
        rd(8'h04, 32'h08080870);
        report_and_stop;
    end
endmodule

`default_nettype wire
